/* include/thermal_pkg.sv */
// Notes on behaviour
// - per-phase temperature follows first-order heating law
// - thermal warning at settable percentage of full
// - trip when temperature reaches one hundred percent
// - trip decision uses the hottest phase
// - full scale is k factor times nominal
// - current warning compares current, ignores temperature
// - stopped motor stretches time constant by factor
// - stopped means all currents below minimum setting
// - block input disables and clears thermal image
// - emergency start input suppresses the trip output
// - run-on timer keeps suppression after emergency release
// - emergency start touches only the trip output
// - mode off, on or alarm-only; only on trips
// - function works only when its enable is set
// - trip held until temperature falls below warning
package thermal_pkg;
   // timing
   localparam int CLK_HZ = 25_000_000;
   localparam int SAMPLE_US = 1000;
   localparam int SAMPLE_CYCLES = CLK_HZ / 1_000_000 * SAMPLE_US;
   localparam int SAMPLES_PER_S = 1_000_000 / SAMPLE_US;
   // tau register unit (0.1 min) times kt unit (0.1) is 0.01 min
   localparam int TAU_UNIT_US = 600_000;
   localparam int ALPHA_FRAC = 40;
   localparam int DELTA_SHIFT = ALPHA_FRAC - 32;
   localparam logic [31:0] ALPHA_NUM = 32'((64'h1 << ALPHA_FRAC) * SAMPLE_US / TAU_UNIT_US);
   localparam logic [5:0] DIV_STEPS = 6'h20;
   localparam int NPH = 3;
   localparam logic [39:0] PCT_FULL = 40'h64;
   // register offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_KFAC = 8'h04;
   localparam logic [7:0] A_TAU = 8'h08;
   localparam logic [7:0] A_WARN = 8'h0c;
   localparam logic [7:0] A_IALARM = 8'h10;
   localparam logic [7:0] A_KT = 8'h14;
   localparam logic [7:0] A_TEMERG = 8'h18;
   localparam logic [7:0] A_IMIN = 8'h1c;
   localparam logic [7:0] A_STATUS = 8'h20;
   localparam logic [7:0] A_EVENT = 8'h24;
   localparam logic [7:0] A_MASK = 8'h28;
   localparam logic [7:0] A_THETA = 8'h2c;
   // field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int EV_WARN = 0;
   localparam int EV_TRIP = 1;
   localparam int EV_IALARM = 2;
   localparam int NEV = 3;
   // reset values (k 1.1 in q8.8, tau 100.0 min, 90 %, 5.00 in q8.8)
   localparam logic [15:0] RST_KFAC = 16'h011a;
   localparam logic [15:0] RST_TAU = 16'h03e8;
   localparam logic [7:0] RST_WARN = 8'h5a;
   localparam logic [15:0] RST_IALARM = 16'h0500;
   localparam logic [7:0] KT_UNITY = 8'h0a;
   localparam logic [15:0] RST_TEMERG = 16'h0064;
   localparam logic [15:0] RST_IMIN = 16'h001a;

   typedef enum logic [1:0] {MODE_OFF = 2'h0, MODE_ON = 2'h1, MODE_ALARM = 2'h2} mode_t;
   typedef enum logic [1:0] {EM_IDLE = 2'b00, EM_HELD = 2'b01, EM_RUNON = 2'b11} emerg_state_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic we;
      logic re;
   } bus_req_t;
   typedef struct packed {
      logic enable;
      mode_t mode;
      logic [15:0] kfac;
      logic [15:0] tau;
      logic [7:0] warn_pct;
      logic [15:0] i_alarm;
      logic [7:0] kt;
      logic [15:0] t_emerg;
      logic [15:0] i_min;
   } cfg_t;
   typedef logic [NPH-1:0][15:0] phase_cur_t;
endpackage

/* rtl/alpha_div.sv */
`timescale 1ns/1ps
// serial restoring divider, one quotient bit per clock
module alpha_div (
   input logic clk,
   input logic rst_n,
   input logic start,
   input logic [31:0] num,
   input logic [23:0] den,
   output logic busy,
   output logic done,
   output logic [31:0] quo
);
   logic [24:0] rem_q, rem_d;
   logic [31:0] quo_q, quo_d;
   logic [23:0] den_q, den_d;
   logic [5:0] cnt_q, cnt_d;
   logic busy_q, busy_d;
   logic done_q, done_d;
   logic [24:0] trial;

   // next state of the divider; start is ignored while busy
   always_comb begin
      rem_d = rem_q;
      quo_d = quo_q;
      den_d = den_q;
      cnt_d = cnt_q;
      busy_d = busy_q;
      done_d = 1'b0;
      trial = {rem_q[23:0], quo_q[31]};
      if (!busy_q) begin
         if (start) begin
            rem_d = '0;
            quo_d = num;
            den_d = den;
            cnt_d = thermal_pkg::DIV_STEPS;
            busy_d = 1'b1;
         end
      end else begin
         if (trial >= {1'b0, den_q}) begin
            rem_d = trial - {1'b0, den_q};
            quo_d = {quo_q[30:0], 1'b1};
         end else begin
            rem_d = trial;
            quo_d = {quo_q[30:0], 1'b0};
         end
         cnt_d = cnt_q - 6'h01;
         if (cnt_q == 6'h01) begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rem_q <= '0;
         quo_q <= '0;
         den_q <= '0;
         cnt_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         rem_q <= rem_d;
         quo_q <= quo_d;
         den_q <= den_d;
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end

   assign busy = busy_q;
   assign done = done_q;
   assign quo = quo_q;
endmodule

/* rtl/thermal_overload_model.sv */
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module thermal_overload_model #(
   parameter int unsigned SAMPLE_CYCLES = thermal_pkg::SAMPLE_CYCLES
) (
   input logic clk,
   input logic rst_n,
   input thermal_pkg::bus_req_t bus_req,
   output logic [31:0] rd_data,
   input thermal_pkg::phase_cur_t phase_cur,
   input logic block_in,
   input logic emerg_in,
   output logic trip,
   output logic warn,
   output logic cur_alarm,
   output logic irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   thermal_pkg::cfg_t cfg_q, cfg_d;
   logic [thermal_pkg::NEV-1:0] ev_q, ev_d, ev_set, mask_q, mask_d;
   logic [31:0] rd_q, rd_d;
   logic [15:0] samp_q, samp_d;
   logic [9:0] sec_q, sec_d;
   logic tick, sec_tick;
   logic [31:0] alpha_q, alpha_d, div_quo;
   logic div_busy, div_done;
   logic [23:0] den;
   logic [7:0] kt_eff;
   logic active, stopped, any_over;
   logic [thermal_pkg::NPH-1:0][31:0] th_int;
   logic [thermal_pkg::NPH-1:0] below_min, over_cur;
   logic [31:0] theta_max, k2;
   logic full_hit, warn_hit;
   thermal_pkg::emerg_state_t em_q, em_d;
   logic [15:0] runon_q, runon_d;
   logic suppress;
   logic hold_q, hold_d, trip_q, trip_d, warn_q, warn_d;
   logic ialarm_q, ialarm_d, stopped_q, irq_q, irq_d;

   // the function runs only when enabled, not off, and not blocked
   assign active = cfg_q.enable && (cfg_q.mode != thermal_pkg::MODE_OFF) && !block_in;

   // register writes; an illegal mode code is stored as off
   always_comb begin
      cfg_d = cfg_q;
      mask_d = mask_q;
      if (bus_req.we) begin
         case (bus_req.addr)
            thermal_pkg::A_CTRL: begin
               cfg_d.enable = bus_req.wdata[thermal_pkg::CTRL_EN_BIT];
               cfg_d.mode = thermal_pkg::mode_t'(bus_req.wdata[thermal_pkg::CTRL_MODE_LSB +: 2]);
               if (bus_req.wdata[thermal_pkg::CTRL_MODE_LSB +: 2] == 2'h3) begin
                  cfg_d.mode = thermal_pkg::MODE_OFF;
               end
            end
            thermal_pkg::A_KFAC: cfg_d.kfac = bus_req.wdata[15:0];
            thermal_pkg::A_TAU: cfg_d.tau = bus_req.wdata[15:0];
            thermal_pkg::A_WARN: cfg_d.warn_pct = bus_req.wdata[7:0];
            thermal_pkg::A_IALARM: cfg_d.i_alarm = bus_req.wdata[15:0];
            thermal_pkg::A_KT: cfg_d.kt = bus_req.wdata[7:0];
            thermal_pkg::A_TEMERG: cfg_d.t_emerg = bus_req.wdata[15:0];
            thermal_pkg::A_IMIN: cfg_d.i_min = bus_req.wdata[15:0];
            thermal_pkg::A_MASK: mask_d = bus_req.wdata[thermal_pkg::NEV-1:0];
            default: begin
            end
         endcase
      end
   end

   // read mux; unmapped addresses read as zero
   always_comb begin
      rd_d = '0;
      if (bus_req.re) begin
         case (bus_req.addr)
            thermal_pkg::A_CTRL: rd_d = {29'h0, cfg_q.mode, cfg_q.enable};
            thermal_pkg::A_KFAC: rd_d = {16'h0, cfg_q.kfac};
            thermal_pkg::A_TAU: rd_d = {16'h0, cfg_q.tau};
            thermal_pkg::A_WARN: rd_d = {24'h0, cfg_q.warn_pct};
            thermal_pkg::A_IALARM: rd_d = {16'h0, cfg_q.i_alarm};
            thermal_pkg::A_KT: rd_d = {24'h0, cfg_q.kt};
            thermal_pkg::A_TEMERG: rd_d = {16'h0, cfg_q.t_emerg};
            thermal_pkg::A_IMIN: rd_d = {16'h0, cfg_q.i_min};
            thermal_pkg::A_STATUS: rd_d = {27'h0, suppress, stopped_q, ialarm_q, trip_q, warn_q};
            thermal_pkg::A_EVENT: rd_d = {29'h0, ev_q};
            thermal_pkg::A_MASK: rd_d = {29'h0, mask_q};
            thermal_pkg::A_THETA: rd_d = theta_max;
            default: rd_d = '0;
         endcase
      end
   end

   // sticky events; a new event in the clearing read cycle survives
   assign ev_set = {ialarm_d & ~ialarm_q, trip_d & ~trip_q, warn_d & ~warn_q};
   always_comb begin
      ev_d = ev_q;
      if (bus_req.re && bus_req.addr == thermal_pkg::A_EVENT) begin
         ev_d = '0;
      end
      ev_d = ev_d | ev_set;
      irq_d = |(ev_d & mask_d);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= '{enable: 1'b0, mode: thermal_pkg::MODE_OFF, kfac: thermal_pkg::RST_KFAC,
                    tau: thermal_pkg::RST_TAU, warn_pct: thermal_pkg::RST_WARN,
                    i_alarm: thermal_pkg::RST_IALARM, kt: thermal_pkg::KT_UNITY,
                    t_emerg: thermal_pkg::RST_TEMERG, i_min: thermal_pkg::RST_IMIN};
         mask_q <= '0;
         ev_q <= '0;
         rd_q <= '0;
         irq_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         mask_q <= mask_d;
         ev_q <= ev_d;
         rd_q <= rd_d;
         irq_q <= irq_d;
      end
   end

   // sample and one-second ticks; run-on resolution is one second
   always_comb begin
      tick = (samp_q == 16'(SAMPLE_CYCLES - 1));
      samp_d = tick ? 16'h0000 : samp_q + 16'h0001;
      sec_tick = tick && (sec_q == 10'(thermal_pkg::SAMPLES_PER_S - 1));
      sec_d = sec_q;
      if (tick) begin
         sec_d = sec_tick ? 10'h000 : sec_q + 10'h001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         samp_q <= '0;
         sec_q <= '0;
      end else begin
         samp_q <= samp_d;
         sec_q <= sec_d;
      end
   end

   // coefficient ts/tau_eff, recomputed continuously so setting changes land fast
   assign stopped = &below_min;
   assign kt_eff = stopped ? cfg_q.kt : thermal_pkg::KT_UNITY;
   always_comb begin
      den = 24'(cfg_q.tau) * 24'(kt_eff);
      if (den == 24'h000000) begin
         den = 24'h000001;
      end
      alpha_d = div_done ? div_quo : alpha_q;
   end

   alpha_div u_div (
      .clk(clk),
      .rst_n(rst_n),
      .start(!div_busy),
      .num(thermal_pkg::ALPHA_NUM),
      .den(den),
      .busy(div_busy),
      .done(div_done),
      .quo(div_quo)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         alpha_q <= '0;
      end else begin
         alpha_q <= alpha_d;
      end
   end

   // per-phase image, q16.48 in units of nominal current squared
   for (genvar p = 0; p < thermal_pkg::NPH; p++) begin : g_phase
      logic [63:0] th_q, th_d;
      logic [31:0] i2;
      logic signed [32:0] diff;
      logic signed [65:0] prod, delta, sum;
      assign i2 = 32'(phase_cur[p]) * 32'(phase_cur[p]);
      assign diff = $signed({1'b0, i2}) - $signed({1'b0, th_q[63:32]});
      assign prod = diff * $signed({1'b0, alpha_q});
      assign delta = prod >>> thermal_pkg::DELTA_SHIFT;
      assign sum = $signed({2'b00, th_q}) + delta;
      assign th_int[p] = th_q[63:32];
      assign below_min[p] = phase_cur[p] < cfg_q.i_min;
      assign over_cur[p] = phase_cur[p] >= cfg_q.i_alarm;
      // emergency start has no path here, so it never clears the image
      always_comb begin
         if (!active) begin
            th_d = '0;
         end else if (!tick) begin
            th_d = th_q;
         end else if (sum[65]) begin
            th_d = '0;
         end else if (sum[64]) begin
            th_d = '1;
         end else begin
            th_d = sum[63:0];
         end
      end
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            th_q <= '0;
         end else begin
            th_q <= th_d;
         end
      end
   end

   // hottest phase against full scale (k times nominal, squared)
   always_comb begin
      theta_max = th_int[0];
      for (int p = 1; p < thermal_pkg::NPH; p++) begin
         if (th_int[p] > theta_max) begin
            theta_max = th_int[p];
         end
      end
   end
   assign k2 = 32'(cfg_q.kfac) * 32'(cfg_q.kfac);
   assign full_hit = theta_max >= k2;
   assign warn_hit = 40'(theta_max) * thermal_pkg::PCT_FULL >= 40'(cfg_q.warn_pct) * 40'(k2);
   assign any_over = |over_cur;

   // emergency start: held while input high, then run-on in whole seconds
   always_comb begin
      em_d = em_q;
      runon_d = runon_q;
      unique case (em_q)
         thermal_pkg::EM_IDLE: begin
            if (emerg_in) begin
               em_d = thermal_pkg::EM_HELD;
            end
         end
         thermal_pkg::EM_HELD: begin
            if (!emerg_in) begin
               em_d = thermal_pkg::EM_RUNON;
               runon_d = cfg_q.t_emerg;
            end
         end
         thermal_pkg::EM_RUNON: begin
            if (emerg_in) begin
               em_d = thermal_pkg::EM_HELD;
            end else if (runon_q == 16'h0000) begin
               em_d = thermal_pkg::EM_IDLE;
            end else if (sec_tick) begin
               runon_d = runon_q - 16'h0001;
            end
         end
         default: em_d = thermal_pkg::EM_IDLE;
      endcase
   end
   assign suppress = (em_q != thermal_pkg::EM_IDLE);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         em_q <= thermal_pkg::EM_IDLE;
         runon_q <= '0;
      end else begin
         em_q <= em_d;
         runon_q <= runon_d;
      end
   end

   // decisions; hold keeps the trip until below the warning level
   always_comb begin
      hold_d = hold_q;
      if (!active) begin
         hold_d = 1'b0;
      end else if (full_hit) begin
         hold_d = 1'b1;
      end else if (!warn_hit) begin
         hold_d = 1'b0;
      end
      trip_d = hold_d && (cfg_q.mode == thermal_pkg::MODE_ON) && !suppress;
      warn_d = active && warn_hit;
      ialarm_d = active && any_over;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_q <= 1'b0;
         trip_q <= 1'b0;
         warn_q <= 1'b0;
         ialarm_q <= 1'b0;
         stopped_q <= 1'b0;
      end else begin
         hold_q <= hold_d;
         trip_q <= trip_d;
         warn_q <= warn_d;
         ialarm_q <= ialarm_d;
         stopped_q <= stopped;
      end
   end

   assign rd_data = rd_q;
   assign trip = trip_q;
   assign warn = warn_q;
   assign cur_alarm = ialarm_q;
   assign irq = irq_q;

   // checks next to the decisions
   a_trip_cause: assert property (
      $rose(trip_q) |-> $past(full_hit || hold_q))
      else $error("trip rose without full-scale temperature");
   a_trip_mode: assert property (
      trip_q |-> $past(active && cfg_q.mode == thermal_pkg::MODE_ON))
      else $error("trip outside on mode");
   a_emerg_block: assert property (
      emerg_in [*2] |=> !trip_q)
      else $error("trip during emergency start");
   a_runon_block: assert property (
      (em_q == thermal_pkg::EM_RUNON) |=> !trip_q)
      else $error("trip during run-on");
   a_block_clear: assert property (
      block_in |=> (theta_max == 32'h0) && !warn_q)
      else $error("image not cleared on block");
   a_emerg_keep: assert property (
      (emerg_in && active && !tick) ##1 active |-> $stable(theta_max))
      else $error("image changed by emergency start");
   a_release_lvl: assert property (
      (hold_q && active && !warn_hit && !full_hit) |=> !hold_q && !trip_q)
      else $error("trip not released below warning");
   a_cur_alarm: assert property (
      (active && any_over) |=> cur_alarm)
      else $error("current warning missed");
   a_stop_detect: assert property (
      $past(rst_n) |-> stopped_q == $past(&below_min))
      else $error("standstill flag wrong");
   a_read_clear: assert property (
      (bus_req.re && bus_req.addr == thermal_pkg::A_EVENT && ev_set == '0) |=> ev_q == '0)
      else $error("event register not cleared by read");
endmodule

/* sim/front_end_model.sv */
`timescale 1ns/1ps
// stands in for the current front end and the binary inputs of the relay
module front_end_model (
   input logic clk,
   input logic rst_n,
   input thermal_pkg::phase_cur_t cur_cmd,
   input logic blk_cmd,
   input logic emerg_cmd,
   output thermal_pkg::phase_cur_t phase_cur,
   output logic block_in,
   output logic emerg_in
);
   // levels follow the commands one edge later, like a sampled front end,
   // so a change never lands in the same step as the block's own sampling
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_cur <= '0;
         block_in <= 1'b0;
         emerg_in <= 1'b0;
      end else begin
         phase_cur <= cur_cmd;
         block_in <= blk_cmd;
         emerg_in <= emerg_cmd;
      end
   end
endmodule

/* sim/thermal_overload_model_tb.sv */
`timescale 1ns/1ps
module thermal_overload_model_tb;
   localparam int sc = 10;
   localparam logic [7:0] ra [13] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
      8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30};
   // status shows standstill after reset, since no current flows yet
   localparam logic [31:0] rv [13] = '{32'h0, 32'h11a, 32'h3e8, 32'h5a, 32'h500, 32'ha,
      32'h64, 32'h1a, 32'h8, 32'h0, 32'h0, 32'h0, 32'h0};
   logic clk;
   logic rst_n;
   thermal_pkg::bus_req_t bus_req;
   logic [31:0] rd_data;
   thermal_pkg::phase_cur_t cur_cmd;
   thermal_pkg::phase_cur_t phase_cur;
   logic blk_cmd;
   logic emerg_cmd;
   logic block_in;
   logic emerg_in;
   logic trip;
   logic warn;
   logic cur_alarm;
   logic irq;
   logic [31:0] th;
   logic [31:0] t0;
   logic [31:0] t1;
   logic [31:0] t2;
   longint d1;
   longint d2;
   int bad;
   int num_errors;
   int tests_run;

   thermal_overload_model #(.SAMPLE_CYCLES(sc)) uut (.clk(clk), .rst_n(rst_n),
      .bus_req(bus_req), .rd_data(rd_data), .phase_cur(phase_cur), .block_in(block_in),
      .emerg_in(emerg_in), .trip(trip), .warn(warn), .cur_alarm(cur_alarm), .irq(irq));
   front_end_model fe (.clk(clk), .rst_n(rst_n), .cur_cmd(cur_cmd), .blk_cmd(blk_cmd),
      .emerg_cmd(emerg_cmd), .phase_cur(phase_cur), .block_in(block_in), .emerg_in(emerg_in));

   // 25 MHz clock
   always #20 clk = ~clk;

   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task chk_t(input logic ok, input string msg);
      chk({31'h0, ok}, 32'h1, msg);
   endtask

   // one-cycle write strobe, released at the edge that takes it
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge clk);
      bus_req <= '0;
   endtask

   // read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
      @(posedge clk);
      bus_req <= '0;
      #1 d = rd_data;
   endtask

   task chk_rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
      logic [31:0] d;
      rd(a, d);
      chk(d, exp, msg);
   endtask

   task samp(input int n);
      repeat (n * sc) @(posedge clk);
   endtask

   // bounded wait for trip (sel 0) or warn (sel 1) to reach a level
   task wait_for(input bit sel, input logic lvl, input int lim);
      int n;
      n = 0;
      while (((sel ? warn : trip) !== lvl) && (n < lim)) begin
         @(posedge clk);
         #1 n++;
      end
      chk_t(n < lim, "output level not reached in time");
   endtask

   task results;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // hang guard, sized above the longest heat, cool and run-on spans
   initial begin
      repeat (90000) @(posedge clk);
      num_errors++;
      $display("MISMATCH %0t watchdog expired", $time);
      results();
   end

   // main sequence
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      bus_req = '0;
      cur_cmd = '0;
      blk_cmd = 1'b0;
      emerg_cmd = 1'b0;
      num_errors = 0;
      tests_run = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (40) @(posedge clk);
      for (int i = 0; i < 13; i++) chk_rd(ra[i], rv[i], "reset value");
      wr(thermal_pkg::A_STATUS, 32'hff);
      chk_rd(thermal_pkg::A_STATUS, 32'h8, "status took a write");
      wr(thermal_pkg::A_KFAC, 32'h200);
      wr(thermal_pkg::A_TAU, 32'h1);
      wr(thermal_pkg::A_IALARM, 32'h300);
      wr(thermal_pkg::A_TEMERG, 32'h2);
      wr(thermal_pkg::A_MASK, 32'h0);
      cur_cmd <= {16'h0400, 16'h0000, 16'h0100};
      // enabled but off, then on but not enabled: image stays cold
      for (int i = 0; i < 2; i++) begin
         wr(thermal_pkg::A_CTRL, (i == 0) ? 32'h1 : 32'h2);
         samp(20);
         chk({29'h0, trip, warn, cur_alarm}, 32'h0, "outputs while inactive");
         chk_rd(thermal_pkg::A_THETA, 32'h0, "image while inactive");
      end
      wr(thermal_pkg::A_CTRL, 32'h7);
      chk_rd(thermal_pkg::A_CTRL, 32'h1, "mode code 3 not stored as off");
      // alarm-only: current warning long before the thermal warning
      wr(thermal_pkg::A_CTRL, 32'h5);
      repeat (3) @(posedge clk);
      #1 chk({28'h0, trip, warn, cur_alarm, irq}, 32'h2, "current warning");
      wr(thermal_pkg::A_MASK, 32'h4);
      @(posedge clk);
      #1 chk({31'h0, irq}, 32'h1, "irq after unmask");
      chk_rd(thermal_pkg::A_EVENT, 32'h4, "event after current warning");
      chk({31'h0, irq}, 32'h0, "irq after event read");
      chk_rd(thermal_pkg::A_EVENT, 32'h0, "event after clear");
      samp(100);
      rd(thermal_pkg::A_THETA, th);
      chk_t(th > 32'd16900 && th < 32'd18400, "heating curve");
      wait_for(1'b1, 1'b1, 2500 * sc);
      rd(thermal_pkg::A_THETA, th);
      chk_t(longint'(th) * 100 >= 90 * 262144 && th < 32'h40000, "warn level");
      samp(500);
      rd(thermal_pkg::A_THETA, th);
      chk_t(th >= 32'h40000 && trip === 1'b0, "no trip in alarm-only");
      chk_rd(thermal_pkg::A_STATUS, 32'h5, "status in alarm-only");
      // switching to on trips at once, on the hottest phase
      wr(thermal_pkg::A_CTRL, 32'h3);
      wait_for(1'b0, 1'b1, 5);
      wr(thermal_pkg::A_MASK, 32'h7);
      @(posedge clk);
      #1 chk({31'h0, irq}, 32'h1, "irq for warn and trip");
      chk_rd(thermal_pkg::A_EVENT, 32'h3, "events warn and trip");
      chk({31'h0, irq}, 32'h0, "irq after event read");
      // cooling at standstill: trip held down to the warn level
      @(posedge clk);
      cur_cmd <= '0;
      samp(3);
      rd(thermal_pkg::A_STATUS, th);
      chk({27'h0, th[4:0]}, 32'hb, "stopped with trip held");
      wait_for(1'b0, 1'b0, 2000 * sc);
      rd(thermal_pkg::A_THETA, th);
      chk_t(longint'(th) * 100 < 90 * 262144 && th >= 32'h38000, "trip release");
      // halved cooling slope once the standstill factor is 2.0
      rd(thermal_pkg::A_THETA, t0);
      samp(100);
      rd(thermal_pkg::A_THETA, t1);
      wr(thermal_pkg::A_KT, 32'h14);
      // a new factor lands only after up to two divider runs, so skip that span
      repeat (70) @(posedge clk);
      rd(thermal_pkg::A_THETA, th);
      samp(100);
      rd(thermal_pkg::A_THETA, t2);
      wr(thermal_pkg::A_KT, 32'ha);
      d1 = longint'(t0) - longint'(t1);
      d2 = longint'(th) - longint'(t2);
      chk_t(d2 * 200 >= d1 * 90 && d2 * 200 <= d1 * 105, "standstill factor");
      // emergency start: hot image, no trip, then the run-on span
      @(posedge clk);
      cur_cmd <= {16'h0400, 16'h0000, 16'h0000};
      emerg_cmd <= 1'b1;
      samp(800);
      rd(thermal_pkg::A_STATUS, th);
      chk({30'h0, th[4], trip}, 32'h2, "trip suppressed");
      rd(thermal_pkg::A_THETA, th);
      chk_t(th >= 32'h40000, "image kept above full scale");
      @(posedge clk);
      emerg_cmd <= 1'b0;
      bad = 0;
      repeat (1000 * sc - 20) begin
         @(posedge clk);
         if (trip !== 1'b0) bad++;
      end
      chk(bad, 32'h0, "trip during run-on");
      wait_for(1'b0, 1'b1, 1000 * sc + 100);
      // block input clears the image and the trip, warning and current outputs
      @(posedge clk);
      blk_cmd <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk({29'h0, trip, warn, cur_alarm}, 32'h0, "outputs while blocked");
      chk_rd(thermal_pkg::A_THETA, 32'h0, "image while blocked");
      @(posedge clk);
      blk_cmd <= 1'b0;
      samp(10);
      rd(thermal_pkg::A_THETA, th);
      chk_t(th > 32'h0 && th < 32'h2000 && warn === 1'b0, "restart from cold");
      results();
   end
endmodule
